// ### core/aswo_sar.sv
// Successive approximation register that steers the comparator reference.
`timescale 1ns/10ps
module aswo_sar (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic init,
  input wire logic step,
  input wire logic comp_high,
  // Codes
  output logic [aswo_pkg::RES_BITS-1:0] trial,
  output logic [aswo_pkg::RES_BITS-1:0] settled
);

  typedef struct packed {
    logic [aswo_pkg::RES_BITS-1:0] trial;
    logic [aswo_pkg::RES_BITS-1:0] mask;
  } aswo_sar_s;

  aswo_sar_s q;
  aswo_sar_s next_q;
  logic [aswo_pkg::RES_BITS-1:0] kept;

  always_comb begin
    next_q = q;
    kept = comp_high ? q.trial : (q.trial & ~q.mask);
    if (init) begin
      next_q.trial = aswo_pkg::SAR_FIRST;
      next_q.mask = aswo_pkg::SAR_FIRST;
    end else if (step) begin
      next_q.mask = q.mask >> 1;
      next_q.trial = kept | (q.mask >> 1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign trial = q.trial;
  assign settled = kept;

endmodule : aswo_sar

// ### core/aswo_timer.sv
// Down counter that times each phase of the sequencer.
`timescale 1ns/10ps
module aswo_timer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic load,
  input wire logic [aswo_pkg::CNT_W-1:0] value,
  // Status
  output logic done
);

  typedef struct packed {
    logic running;
    logic [aswo_pkg::CNT_W-1:0] count;
  } aswo_timer_s;

  aswo_timer_s q;
  aswo_timer_s next_q;

  always_comb begin
    next_q = q;
    if (load) begin
      next_q.running = 1'h1;
      next_q.count = value;
    end else if (q.running) begin
      if (q.count == '0) begin
        next_q.running = 1'h0;
      end else begin
        next_q.count = q.count - 12'h001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign done = q.running && (q.count == '0);

endmodule : aswo_timer

// ### core/aswo_top.sv
// Software triggered converter sequencer with an AHB-Lite register slave.
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps

module aswo_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Analog front end
  input wire logic comp_high,
  output logic comp_power,
  output logic sample_hold,
  output logic [2:0] chan_sel,
  output logic [11:0] dac_code,
  // Events
  output logic conversion_end_irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    aswo_pkg::aswo_state_e st;
    logic converter_enable_bit;
    logic conversion_start_bit;
    logic oneshot;
    logic res12;
    logic [2:0] chan;
    logic [11:0] conversion_result_reg;
    logic [7:0] compare_upper_limit;
    logic [7:0] compare_lower_limit;
    logic miss;
    logic [3:0] bitcnt;
    logic [11:0] conv_age;
    logic irq;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic rd_wait;
    logic [31:0] rdata;
  } aswo_top_s;

  localparam aswo_top_s TOP_RST = '{
    st: aswo_pkg::ST_IDLE,
    converter_enable_bit: 1'h0,
    conversion_start_bit: 1'h0,
    oneshot: aswo_pkg::ONESHOT_RST,
    res12: aswo_pkg::RES12_RST,
    chan: aswo_pkg::CH_RST,
    conversion_result_reg: 12'h000,
    compare_upper_limit: aswo_pkg::UPPER_RST,
    compare_lower_limit: aswo_pkg::LOWER_RST,
    miss: 1'h0,
    bitcnt: 4'h0,
    conv_age: 12'h000,
    irq: 1'h0,
    ap_valid: 1'h0,
    ap_write: 1'h0,
    ap_addr: 8'h00,
    rd_wait: 1'h0,
    rdata: 32'h0000_0000
  };

  aswo_top_s q;
  aswo_top_s next_q;

  logic t_load;
  logic [aswo_pkg::CNT_W-1:0] t_value;
  logic t_done;
  logic s_init;
  logic s_step;
  logic [11:0] s_trial;
  logic [11:0] s_settled;
  logic [11:0] final_val;
  logic in_range;
  logic finish;
  logic ctrl_wr;
  logic bus_wr;

  // ----------------------------------------------------------------------
  // Phase timer and approximation register
  // ----------------------------------------------------------------------
  aswo_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(t_load),
    .value(t_value),
    .done(t_done)
  );

  aswo_sar u_sar (
    .hclk(hclk),
    .hresetn(hresetn),
    .init(s_init),
    .step(s_step),
    .comp_high(comp_high),
    .trial(s_trial),
    .settled(s_settled)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.irq = 1'h0;
    next_q.conv_age = q.conv_age + 12'h001;
    t_load = 1'h0;
    t_value = '0;
    s_init = 1'h0;
    s_step = 1'h0;
    finish = 1'h0;
    final_val = q.res12 ? s_settled : {s_settled[11:2], 2'b00};
    in_range = (final_val[11:aswo_pkg::LIMIT_LSB] <= q.compare_upper_limit) &&
               (final_val[11:aswo_pkg::LIMIT_LSB] >= q.compare_lower_limit);
    bus_wr = q.ap_valid && q.ap_write;
    ctrl_wr = bus_wr && (q.ap_addr == aswo_pkg::CTRL_OFS);

    unique case (q.st)
      aswo_pkg::ST_IDLE: begin
        if (q.conversion_start_bit) begin
          if (q.converter_enable_bit) begin
            next_q.st = aswo_pkg::ST_SAMPLE;
            t_load = 1'h1;
            t_value = aswo_pkg::SAMPLE_LOAD;
            s_init = 1'h1;
            next_q.conv_age = 12'h000;
          end else begin
            next_q.st = aswo_pkg::ST_STAB;
            t_load = 1'h1;
            t_value = aswo_pkg::STAB_LOAD;
          end
        end
      end
      aswo_pkg::ST_STAB: begin
        if (t_done) begin
          next_q.st = aswo_pkg::ST_SAMPLE;
          t_load = 1'h1;
          t_value = aswo_pkg::SAMPLE_LOAD;
          s_init = 1'h1;
          next_q.conv_age = 12'h000;
        end
      end
      aswo_pkg::ST_SAMPLE: begin
        if (t_done) begin
          next_q.st = aswo_pkg::ST_CONV;
          t_load = 1'h1;
          t_value = aswo_pkg::STEP_LOAD;
          next_q.bitcnt = 4'h0;
        end
      end
      aswo_pkg::ST_CONV: begin
        if (t_done) begin
          s_step = 1'h1;
          if (q.bitcnt == aswo_pkg::LAST_BIT) begin
            finish = 1'h1;
            next_q.conversion_result_reg = final_val;
            if (in_range) begin
              next_q.irq = 1'h1;
            end else begin
              next_q.miss = 1'h1;
            end
            if (q.oneshot) begin
              next_q.conversion_start_bit = 1'h0;
              next_q.st = aswo_pkg::ST_IDLE;
            end else begin
              next_q.st = aswo_pkg::ST_SAMPLE;
              t_load = 1'h1;
              t_value = aswo_pkg::SAMPLE_LOAD;
              s_init = 1'h1;
              next_q.conv_age = 12'h000;
            end
          end else begin
            next_q.bitcnt = q.bitcnt + 4'h1;
            t_load = 1'h1;
            t_value = aswo_pkg::STEP_LOAD;
          end
        end
      end
      default: begin
        next_q.st = aswo_pkg::ST_IDLE;
      end
    endcase

    // Bus address and read data phases.
    if (q.rd_wait) begin
      next_q.rd_wait = 1'h0;
      unique case (q.ap_addr)
        aswo_pkg::CTRL_OFS: begin
          next_q.rdata = {25'h0, q.chan, q.res12, q.oneshot,
                          q.conversion_start_bit, q.converter_enable_bit};
        end
        aswo_pkg::RESULT_OFS: begin
          next_q.rdata = {20'h0, q.conversion_result_reg};
        end
        aswo_pkg::UPPER_OFS: begin
          next_q.rdata = {24'h0, q.compare_upper_limit};
        end
        aswo_pkg::LOWER_OFS: begin
          next_q.rdata = {24'h0, q.compare_lower_limit};
        end
        aswo_pkg::STATUS_OFS: begin
          next_q.rdata = {29'h0, comp_power, q.miss, (q.st != aswo_pkg::ST_IDLE)};
        end
        default: begin
          next_q.rdata = 32'h0000_0000;
        end
      endcase
    end else if (hready) begin
      next_q.ap_valid = hsel && htrans[1];
      next_q.ap_write = hwrite && (hsize == aswo_pkg::HSIZE_WORD);
      next_q.ap_addr = haddr[7:0];
      next_q.rd_wait = hsel && htrans[1] && !hwrite;
    end

    // Bus write data phase; software writes follow the hardware updates, but a miss clear loses to a miss set in the same cycle.
    if (bus_wr) begin
      unique case (q.ap_addr)
        aswo_pkg::CTRL_OFS: begin
          next_q.converter_enable_bit = hwdata[aswo_pkg::CTRL_EN_BIT];
          next_q.oneshot = hwdata[aswo_pkg::CTRL_ONESHOT_BIT];
          next_q.res12 = hwdata[aswo_pkg::CTRL_RES12_BIT];
          next_q.chan = hwdata[aswo_pkg::CTRL_CH_MSB:aswo_pkg::CTRL_CH_LSB];
          if (hwdata[aswo_pkg::CTRL_START_BIT]) begin
            next_q.conversion_start_bit = 1'h1;
          end else begin
            next_q.conversion_start_bit = 1'h0;
            next_q.st = aswo_pkg::ST_IDLE;
          end
        end
        aswo_pkg::UPPER_OFS: begin
          next_q.compare_upper_limit = hwdata[7:0];
        end
        aswo_pkg::LOWER_OFS: begin
          next_q.compare_lower_limit = hwdata[7:0];
        end
        aswo_pkg::STATUS_OFS: begin
          if (hwdata[aswo_pkg::STAT_MISS_BIT] && !(finish && !in_range)) begin
            next_q.miss = 1'h0;
          end
        end
        default: begin
          next_q.miss = next_q.miss;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= TOP_RST;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hreadyout = !q.rd_wait;
  assign hresp = 1'h0;
  assign hrdata = q.rdata;
  assign comp_power = q.converter_enable_bit || (q.st != aswo_pkg::ST_IDLE);
  assign sample_hold = (q.st == aswo_pkg::ST_SAMPLE);
  assign chan_sel = q.chan;
  assign dac_code = s_trial;
  assign conversion_end_irq = q.irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking chk_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence seq_finish;
    (q.st == aswo_pkg::ST_CONV) && t_done && (q.bitcnt == aswo_pkg::LAST_BIT);
  endsequence

  sequence seq_wait_start;
    (q.st == aswo_pkg::ST_IDLE) && q.conversion_start_bit && !q.converter_enable_bit;
  endsequence

  chk_wait_stopped: assert property (
    ((q.st == aswo_pkg::ST_IDLE) && !q.conversion_start_bit && !q.converter_enable_bit)
      |-> !comp_power ##1 ((q.st == aswo_pkg::ST_IDLE) && !sample_hold))
    else $error("comparator powered while waiting");

  chk_start_begins: assert property (
    ((q.st == aswo_pkg::ST_IDLE) && q.conversion_start_bit && !ctrl_wr)
      |=> (q.st != aswo_pkg::ST_IDLE))
    else $error("start request did not begin a conversion");

  chk_stab_first: assert property (
    (seq_wait_start ##0 !ctrl_wr) |=> (q.st == aswo_pkg::ST_STAB)
      ##1 ((q.st == aswo_pkg::ST_STAB) || $past(ctrl_wr))[*7])
    else $error("sampling began without comparator settling");

  chk_result_irq: assert property (
    (seq_finish ##0 in_range) |=> conversion_end_irq &&
      (q.conversion_result_reg == $past(final_val)))
    else $error("result not stored with end interrupt");

  chk_oneshot_stop: assert property (
    (seq_finish ##0 (q.oneshot && !ctrl_wr))
      |=> (!q.conversion_start_bit && (q.st == aswo_pkg::ST_IDLE)))
    else $error("one-shot conversion did not stop");

  chk_single_conv: assert property (
    (q.st == aswo_pkg::ST_IDLE) |=> ((q.st == aswo_pkg::ST_IDLE) ||
      $past(q.conversion_start_bit)))
    else $error("conversion began without a start request");

  chk_chan_held: assert property (
    ((q.st != aswo_pkg::ST_IDLE) && !ctrl_wr) |=> $stable(chan_sel))
    else $error("channel changed without a control write");

  chk_res_coarse: assert property (
    (conversion_end_irq && !$past(q.res12)) |-> (q.conversion_result_reg[1:0] == 2'b00))
    else $error("low result bits set at reduced resolution");

  chk_conv_time: assert property (
    seq_finish |-> (q.conv_age == aswo_pkg::CONV_AGE_LAST))
    else $error("conversion length is not 2816 cycles");

  chk_limit_gate: assert property (
    conversion_end_irq |-> ((q.conversion_result_reg[11:4] <= q.compare_upper_limit) &&
      (q.conversion_result_reg[11:4] >= q.compare_lower_limit)))
    else $error("end interrupt for a result outside the limits");

  chk_irq_pulse: assert property (
    conversion_end_irq |=> !conversion_end_irq)
    else $error("end interrupt longer than one cycle");

endmodule : aswo_top

// ### inc/aswo_pkg.sv
// Constants, state codes and register layout of the converter sequencer.
package aswo_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] RESULT_OFS = 8'h04;
  localparam logic [7:0] UPPER_OFS = 8'h08;
  localparam logic [7:0] LOWER_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_ONESHOT_BIT = 2;
  localparam int CTRL_RES12_BIT = 3;
  localparam int CTRL_CH_LSB = 4;
  localparam int CTRL_CH_MSB = 6;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_MISS_BIT = 1;
  localparam int STAT_PWR_BIT = 2;
  localparam int LIMIT_LSB = 4;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic ONESHOT_RST = 1'h1;
  localparam logic RES12_RST = 1'h1;
  localparam logic [2:0] CH_RST = 3'h2;
  localparam logic [7:0] UPPER_RST = 8'hff;
  localparam logic [7:0] LOWER_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CNT_W = 12;
  localparam int RES_BITS = 12;
  localparam int CLK_PERIOD_NS = 4;
  localparam int STAB_NS = 1000;
  localparam int STAB_CYCLES = (STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYCLES = 2816;
  localparam int STEP_CYCLES = 200;
  localparam int SAMPLE_CYCLES = CONV_CYCLES - RES_BITS * STEP_CYCLES;
  localparam logic [CNT_W-1:0] STAB_LOAD = CNT_W'(STAB_CYCLES - 1);
  localparam logic [CNT_W-1:0] SAMPLE_LOAD = CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] STEP_LOAD = CNT_W'(STEP_CYCLES - 1);
  localparam logic [CNT_W-1:0] CONV_AGE_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [3:0] LAST_BIT = 4'(RES_BITS - 1);
  localparam logic [RES_BITS-1:0] SAR_FIRST = 12'h800;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_STAB = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_CONV = 4'b1000
  } aswo_state_e;

endpackage : aswo_pkg

// ### verif/tb_top.sv
// Self-checking bench for the software triggered converter sequencer.
`timescale 1ns/10ps
module tb_top;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic comp_high = 1'b0;
  logic comp_power;
  logic sample_hold;
  logic [2:0] chan_sel;
  logic [11:0] dac_code;
  logic conversion_end_irq;
  logic [31:0] seed = 32'h066d;
  logic [11:0] ana [8];
  logic pw_d = 1'b0;
  logic sh_d = 1'b0;
  logic [11:0] sh_code = 12'h000;
  logic [31:0] r;
  int cyc = 0;
  int pw_at = 0;
  int sh_at = 0;
  int irq_at = 0;
  int irq_n = 0;
  int fail_count = 0;
  int comparisons = 0;
  int n0;
  int t0;

  always #2 hclk = ~hclk;
  assign hready = hreadyout;

  aswo_top DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comp_high(comp_high),
    .comp_power(comp_power), .sample_hold(sample_hold), .chan_sel(chan_sel),
    .dac_code(dac_code), .conversion_end_irq(conversion_end_irq)
  );

  // ----------------------------------------------------------------------
  // Analog front end and event monitor
  // ----------------------------------------------------------------------
  always @(posedge hclk) begin
    comp_high <= (ana[chan_sel] >= dac_code);
    cyc <= cyc + 1;
    pw_d <= comp_power;
    sh_d <= sample_hold;
    if (comp_power && !pw_d) pw_at <= cyc;
    if (sample_hold && !sh_d) sh_at <= cyc;
    if (sample_hold && !sh_d) sh_code <= dac_code;
    if (conversion_end_irq) begin
      irq_at <= cyc;
      irq_n <= irq_n + 1;
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_cycles(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_cycles

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hsize <= aswo_pkg::HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    ahb(1'b0, a, 32'h00000000, q);
  endtask : rd

  task automatic wait_irq(input int n);
    for (int i = 0; i < 4000 && irq_n == n; i++) @(posedge hclk);
    @(posedge hclk);
  endtask : wait_irq

  // Starts one conversion and checks timing, result and the end of the run.
  task automatic one_shot(input logic [31:0] ctrl, input int ch, input logic stab);
    logic [11:0] expv;
    int n;
    n = irq_n;
    expv = ctrl[aswo_pkg::CTRL_RES12_BIT] ? ana[ch] : (ana[ch] / 4) * 4;
    wr(aswo_pkg::CTRL_OFS, ctrl | 32'h2);
    wait_irq(n);
    chk_cycles("irq count", n + 1, irq_n);
    if (stab) chk_cycles("settle", aswo_pkg::STAB_CYCLES, sh_at - pw_at);
    chk_cycles("conv time", aswo_pkg::CONV_CYCLES, irq_at - sh_at);
    chk_word("first trial", {20'h0, aswo_pkg::SAR_FIRST}, {20'h0, sh_code});
    chk_word("chan_sel", ch, {29'h0, chan_sel});
    rd(aswo_pkg::RESULT_OFS, r);
    chk_word("result", {20'h0, expv}, r);
    chk_word("hresp", 32'h0, {31'h0, hresp});
    rd(aswo_pkg::CTRL_OFS, r);
    chk_word("ctrl", ctrl, r);
    repeat (300) @(posedge hclk);
    chk_cycles("irq after end", n + 1, irq_n);
    rd(aswo_pkg::STATUS_OFS, r);
    chk_word("busy", 32'h0, r & 32'h1);
  endtask : one_shot

  task automatic tally_and_finish();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge hclk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      ana[i] = seed[11:0];
    end
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    wr(8'h14, 32'h12345678);
    rd(aswo_pkg::CTRL_OFS, r);
    chk_word("ctrl reset", 32'h2c, r);
    rd(aswo_pkg::UPPER_OFS, r);
    chk_word("upper reset", 32'hff, r);
    rd(aswo_pkg::LOWER_OFS, r);
    chk_word("lower reset", 32'h0, r);
    rd(8'h14, r);
    chk_word("unmapped", 32'h0, r);
    repeat (20) @(posedge hclk);
    chk_word("idle power", 32'h0, {30'h0, comp_power, sample_hold});
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      ana[2] = seed[11:0];
      one_shot(32'h2c, 2, 1'b1);
    end
    one_shot(32'h5c, 5, 1'b1);
    one_shot(32'h24, 2, 1'b1);
    one_shot(32'h2d, 2, 1'b0);
    n0 = irq_n;
    wr(aswo_pkg::CTRL_OFS, 32'h2a);
    wait_irq(n0);
    t0 = irq_at;
    wait_irq(n0 + 1);
    chk_cycles("repeat period", aswo_pkg::CONV_CYCLES, irq_at - t0);
    chk_cycles("repeat irqs", n0 + 2, irq_n);
    rd(aswo_pkg::CTRL_OFS, r);
    chk_word("repeat ctrl", 32'h2a, r);
    wr(aswo_pkg::CTRL_OFS, 32'h2c);
    for (int k = 0; k < 2; k++) begin
      ana[2] = k ? 12'hf00 : 12'h100;
      wr(k ? aswo_pkg::UPPER_OFS : aswo_pkg::LOWER_OFS, k ? 32'h80 : 32'h20);
      n0 = irq_n;
      wr(aswo_pkg::CTRL_OFS, 32'h2e);
      r = 32'h1;
      for (int i = 0; i < 2000 && r[0] !== 1'b0; i++) rd(aswo_pkg::STATUS_OFS, r);
      chk_word("miss status", 32'h2, r);
      chk_cycles("irq out of range", n0, irq_n);
      rd(aswo_pkg::RESULT_OFS, r);
      chk_word("stored result", {20'h0, ana[2]}, r);
      wr(aswo_pkg::STATUS_OFS, 32'h2);
      rd(aswo_pkg::STATUS_OFS, r);
      chk_word("miss cleared", 32'h0, r);
    end
    wr(aswo_pkg::UPPER_OFS, 32'hff);
    wr(aswo_pkg::LOWER_OFS, 32'h0);
    n0 = irq_n;
    wr(aswo_pkg::CTRL_OFS, 32'h2e);
    repeat (100) @(posedge hclk);
    wr(aswo_pkg::CTRL_OFS, 32'h2c);
    rd(aswo_pkg::STATUS_OFS, r);
    chk_word("abort status", 32'h0, r);
    repeat (3200) @(posedge hclk);
    chk_cycles("irq after abort", n0, irq_n);
    chk_word("abort power", 32'h0, {30'h0, comp_power, sample_hold});
    tally_and_finish();
  end
endmodule : tb_top
